// File: common/sles_pkg.sv
// Constants, register indices and carrier types for the lane error status block.
// Assumes a 32-bit AXI4-Lite master and lane decoders on the same clock.
package sles_pkg;
    localparam int AXI_AW = 16;
    localparam int LANES = 8;
    localparam int NUM_LINKS = 2;
    localparam int PAGE_W = 1;
    localparam int CNT_W = 8;
    localparam int NIT_LANES = 2;
    localparam int NIT_LSB = 6;
    localparam int PAGE_LSB = 0;
    localparam int ALIGN_LSB = 0;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_LINK_PAGE = 12'h300;
    localparam logic [11:0] IDX_LANE_ALIGN = 12'h46c;
    localparam logic [11:0] IDX_DISP_FLAGS = 12'h46d;
    localparam logic [11:0] IDX_NIT_FLAGS = 12'h46e;
    localparam logic [11:0] IDX_ERR_THRESH = 12'h480;

    localparam logic [PAGE_W-1:0] PAGE_RST = 1'h0;
    localparam logic [7:0] THRESH_RST = 8'h01;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [AXI_AW-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [AXI_AW-1:0] araddr;
        logic arvalid;
        logic rready;
    } sles_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sles_axi_rsp_t;

    typedef struct packed {
        logic lane0_align_ok;
        logic [LANES-1:0] disparity_evt;
        logic [NIT_LANES-1:0] invalid_code_evt;
    } sles_lane_evt_t;

    function automatic logic [11:0] sles_reg_index(input logic [AXI_AW-1:0] addr);
        return addr[13:2];
    endfunction
endpackage

// File: src/sles_err_counter.sv
// Saturating per-lane error counter.
// Assumes one event pulse per detected error, on the same clock.
module sles_err_counter #(
    parameter int CNT_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic evt,
    output logic [CNT_W-1:0] count
);
    typedef struct packed {
        logic [CNT_W-1:0] count;
    } sles_cnt_state_t;

    sles_cnt_state_t st;
    sles_cnt_state_t nx;

    always_comb begin
        nx = st;
        if (evt && st.count != {CNT_W{1'b1}}) begin
            nx.count = CNT_W'(st.count + 1'b1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st.count <= '0;
        end else if (ce) begin
            st <= nx;
        end
    end

    assign count = st.count;

    a_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && evt && st.count != {CNT_W{1'b1}}) |=> (st.count == CNT_W'($past(st.count) + 1'b1)))
        else $error("counter did not step on error event");
    a_count_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !evt) |=> $stable(st.count))
        else $error("counter moved without error event");
endmodule

// File: src/sles_lane_status.sv
// Lane deskew and lane error status registers behind an AXI4-Lite slave.
// Assumes lane event pulses and alignment levels come from logic on aclk.
//
// Local design decision: the AXI4-Lite interface to the registers.
module sles_lane_status (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input sles_pkg::sles_axi_req_t axi_req,
    output sles_pkg::sles_axi_rsp_t axi_rsp,
    input sles_pkg::sles_lane_evt_t lane_evt [sles_pkg::NUM_LINKS]
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [11:0] aw_idx;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [sles_pkg::PAGE_W-1:0] page;
        logic [7:0] thresh;
        logic [sles_pkg::NUM_LINKS-1:0] align;
    } sles_top_state_t;

    sles_top_state_t st;
    sles_top_state_t nx;

    logic [sles_pkg::CNT_W-1:0] disp_cnt [sles_pkg::NUM_LINKS][sles_pkg::LANES];
    logic [sles_pkg::CNT_W-1:0] nit_cnt [sles_pkg::NUM_LINKS][sles_pkg::NIT_LANES];
    logic [sles_pkg::LANES-1:0] disp_flags;
    logic [sles_pkg::NIT_LANES-1:0] nit_flags;
    logic [7:0] rd_byte;
    logic [1:0] rd_resp;
    logic [1:0] wr_resp;

    // One disparity counter per link and lane; invalid code counters per link for the first NIT_LANES lanes only
    for (genvar l = 0; l < sles_pkg::NUM_LINKS; l++) begin : g_link
        for (genvar i = 0; i < sles_pkg::LANES; i++) begin : g_disp
            sles_err_counter #(.CNT_W(sles_pkg::CNT_W)) u_disp (
                .aclk(aclk),
                .aresetn(aresetn),
                .ce(ce),
                .evt(lane_evt[l].disparity_evt[i]),
                .count(disp_cnt[l][i])
            );
        end
        for (genvar k = 0; k < sles_pkg::NIT_LANES; k++) begin : g_nit
            sles_err_counter #(.CNT_W(sles_pkg::CNT_W)) u_nit (
                .aclk(aclk),
                .aresetn(aresetn),
                .ce(ce),
                .evt(lane_evt[l].invalid_code_evt[k]),
                .count(nit_cnt[l][k])
            );
        end
    end

    // Flags of the selected link page
    always_comb begin
        for (int i = 0; i < sles_pkg::LANES; i++) begin
            disp_flags[i] = disp_cnt[st.page][i] >= st.thresh;
        end
        for (int k = 0; k < sles_pkg::NIT_LANES; k++) begin
            nit_flags[k] = nit_cnt[st.page][k] >= st.thresh;
        end
    end

    // Read word for the address offered on the read channel
    always_comb begin
        rd_byte = 8'h00;
        rd_resp = sles_pkg::RESP_OKAY;
        unique case (sles_pkg::sles_reg_index(axi_req.araddr))
            sles_pkg::IDX_LINK_PAGE: begin
                rd_byte[sles_pkg::PAGE_LSB +: sles_pkg::PAGE_W] = st.page;
            end
            sles_pkg::IDX_ERR_THRESH: begin
                rd_byte = st.thresh;
            end
            sles_pkg::IDX_LANE_ALIGN: begin
                rd_byte[sles_pkg::ALIGN_LSB] = st.align[st.page];
            end
            sles_pkg::IDX_DISP_FLAGS: begin
                rd_byte = disp_flags;
            end
            sles_pkg::IDX_NIT_FLAGS: begin
                rd_byte[sles_pkg::NIT_LSB +: sles_pkg::NIT_LANES] = nit_flags;
            end
            default: begin
                rd_resp = sles_pkg::RESP_SLVERR;
            end
        endcase
    end

    always_comb begin
        nx = st;
        wr_resp = sles_pkg::RESP_OKAY;
        for (int l = 0; l < sles_pkg::NUM_LINKS; l++) begin
            nx.align[l] = lane_evt[l].lane0_align_ok;
        end
        if (axi_req.awvalid && st.awready) begin
            nx.aw_got = 1'b1;
            nx.aw_idx = sles_pkg::sles_reg_index(axi_req.awaddr);
        end
        if (axi_req.wvalid && st.wready) begin
            nx.w_got = 1'b1;
            nx.wdata = axi_req.wdata;
            nx.wstrb = axi_req.wstrb;
        end
        if (axi_req.bready && st.bvalid) begin
            nx.bvalid = 1'b0;
        end
        if (nx.aw_got && nx.w_got && !nx.bvalid) begin
            unique case (nx.aw_idx)
                sles_pkg::IDX_LINK_PAGE: begin
                    if (nx.wstrb[0]) begin
                        nx.page = nx.wdata[sles_pkg::PAGE_LSB +: sles_pkg::PAGE_W];
                    end
                end
                sles_pkg::IDX_ERR_THRESH: begin
                    if (nx.wstrb[0]) begin
                        nx.thresh = nx.wdata[7:0];
                    end
                end
                // Status words accept the write and keep their value
                sles_pkg::IDX_LANE_ALIGN, sles_pkg::IDX_DISP_FLAGS, sles_pkg::IDX_NIT_FLAGS: begin
                    wr_resp = sles_pkg::RESP_OKAY;
                end
                default: begin
                    wr_resp = sles_pkg::RESP_SLVERR;
                end
            endcase
            nx.bresp = wr_resp;
            nx.bvalid = 1'b1;
            nx.aw_got = 1'b0;
            nx.w_got = 1'b0;
        end
        nx.awready = !nx.aw_got && !nx.bvalid;
        nx.wready = !nx.w_got && !nx.bvalid;
        if (axi_req.rready && st.rvalid) begin
            nx.rvalid = 1'b0;
        end
        if (axi_req.arvalid && st.arready) begin
            nx.rvalid = 1'b1;
            nx.rdata = {24'h000000, rd_byte};
            nx.rresp = rd_resp;
        end
        nx.arready = !nx.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '{awready: 1'b1, wready: 1'b1, aw_got: 1'b0, w_got: 1'b0, aw_idx: 12'h000,
                wdata: 32'h00000000, wstrb: 4'h0, bvalid: 1'b0, bresp: sles_pkg::RESP_OKAY,
                arready: 1'b1, rvalid: 1'b0, rdata: 32'h00000000, rresp: sles_pkg::RESP_OKAY,
                page: sles_pkg::PAGE_RST, thresh: sles_pkg::THRESH_RST, align: '0};
        end else if (ce) begin
            st <= nx;
        end
    end

    assign axi_rsp.awready = st.awready;
    assign axi_rsp.wready = st.wready;
    assign axi_rsp.bvalid = st.bvalid;
    assign axi_rsp.bresp = st.bresp;
    assign axi_rsp.arready = st.arready;
    assign axi_rsp.rvalid = st.rvalid;
    assign axi_rsp.rdata = st.rdata;
    assign axi_rsp.rresp = st.rresp;

    // Helpers watched by the checks below
    logic sel_align;
    logic [sles_pkg::CNT_W-1:0] disp_sel0;
    logic [11:0] rd_idx;
    logic [sles_pkg::PAGE_W-1:0] wr_page_field;
    assign sel_align = st.align[st.page];
    assign disp_sel0 = disp_cnt[st.page][0];
    assign rd_idx = sles_pkg::sles_reg_index(axi_req.araddr);
    assign wr_page_field = axi_req.wdata[sles_pkg::PAGE_LSB +: sles_pkg::PAGE_W];

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_rd_req(logic [11:0] idx);
        ce && axi_req.arvalid && st.arready && rd_idx == idx;
    endsequence
    sequence s_rd_ans;
        st.rvalid && st.rresp == sles_pkg::RESP_OKAY;
    endsequence
    sequence s_page_wr;
        ce && !st.bvalid && axi_req.awvalid && st.awready && axi_req.wvalid && st.wready && axi_req.wstrb[0]
            && sles_pkg::sles_reg_index(axi_req.awaddr) == sles_pkg::IDX_LINK_PAGE;
    endsequence

    a_align_read: assert property (
        s_rd_req(sles_pkg::IDX_LANE_ALIGN) |=> s_rd_ans ##0 st.rdata == {31'h00000000, $past(sel_align)})
        else $error("alignment read does not match selected link");
    a_disp_read: assert property (
        s_rd_req(sles_pkg::IDX_DISP_FLAGS) |=> s_rd_ans ##0 st.rdata == {24'h000000, $past(disp_flags)})
        else $error("disparity flags read wrong");
    a_flag_cross: assert property (
        ($rose(disp_flags[0]) && $stable(st.thresh) && $stable(st.page)) |-> disp_sel0 == st.thresh)
        else $error("disparity flag rose off the threshold");
    a_nit_read: assert property (
        s_rd_req(sles_pkg::IDX_NIT_FLAGS) |=> s_rd_ans ##0 st.rdata[31:8] == 24'h000000
            ##0 st.rdata[7:6] == $past(nit_flags) ##0 st.rdata[5:0] == 6'h00)
        else $error("invalid code flags read wrong");
    a_page_select: assert property (
        s_page_wr |=> st.page == $past(wr_page_field) ##0 st.bvalid)
        else $error("link page not taken from write");
    a_reset_zero: assert property (disable iff (1'b0)
        !aresetn |=> (disp_flags == 8'h00 && nit_flags == 2'h0 && st.align == '0))
        else $error("status not zero after reset");
endmodule

// File: sim/sles_lane_model.sv
// Far-side lane decoder stand-in: error event bursts and alignment levels per link.
// Assumes commands from the bench on aclk; events drop to zero between bursts.
module sles_lane_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    input wire logic link,
    input wire logic [7:0] disp,
    input wire logic [1:0] nit,
    input wire logic [7:0] len,
    input wire logic [1:0] align,
    output sles_pkg::sles_lane_evt_t lane_evt [sles_pkg::NUM_LINKS],
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;
    logic link_r;
    logic [7:0] disp_r;
    logic [1:0] nit_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 8'h00;
        end else if (go) begin
            cnt_r <= len;
            link_r <= link;
            disp_r <= disp;
            nit_r <= nit;
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end
    assign busy = cnt_r != 8'h00;
    // One event per cycle per flagged lane while a burst runs
    always_comb begin
        for (int l = 0; l < sles_pkg::NUM_LINKS; l++) begin
            lane_evt[l].lane0_align_ok = align[l];
            lane_evt[l].disparity_evt = (busy && link_r == 1'(l)) ? disp_r : 8'h00;
            lane_evt[l].invalid_code_evt = (busy && link_r == 1'(l)) ? nit_r : 2'h0;
        end
    end
endmodule

// File: sim/testbench.sv
// Self-checking bench for the lane status block over AXI4-Lite.
// Assumes the lane model as far side; ce held high except during one injected burst.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [11:0] idx; logic [31:0] exp; logic [1:0] resp;} sles_row_t;
    logic aclk, aresetn, ce, go, link, busy;
    logic [7:0] disp, len;
    logic [1:0] nit, align;
    sles_pkg::sles_axi_req_t req;
    sles_pkg::sles_axi_rsp_t rsp;
    sles_pkg::sles_lane_evt_t evt [sles_pkg::NUM_LINKS];
    int error_cnt = 0;
    int n_tests = 0;
    sles_row_t rows [6] = '{'{sles_pkg::IDX_LINK_PAGE, 32'h0, sles_pkg::RESP_OKAY},
        '{sles_pkg::IDX_LANE_ALIGN, 32'h0, sles_pkg::RESP_OKAY},
        '{sles_pkg::IDX_DISP_FLAGS, 32'h0, sles_pkg::RESP_OKAY},
        '{sles_pkg::IDX_NIT_FLAGS, 32'h0, sles_pkg::RESP_OKAY},
        '{sles_pkg::IDX_ERR_THRESH, 32'h1, sles_pkg::RESP_OKAY},
        '{12'h46f, 32'h0, sles_pkg::RESP_SLVERR}};
    sles_lane_status sles_lane_status_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .axi_req(req),
        .axi_rsp(rsp), .lane_evt(evt));
    sles_lane_model sles_lane_model_i (.aclk(aclk), .aresetn(aresetn), .go(go), .link(link),
        .disp(disp), .nit(nit), .len(len), .align(align), .lane_evt(evt), .busy(busy));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic timeout(input logic done);
        if (!done) begin
            error_cnt++;
            $display("unexpected wait: expected answer, seen none");
            end_sim();
        end
    endtask
    // Handshakes judged at the falling edge, taken at the next rising edge
    task automatic axw(input logic [11:0] idx, input logic [31:0] d, output logic [1:0] r);
        logic a, w, b;
        int i;
        b = 1'b0;
        @(posedge aclk);
        req.awaddr <= {2'h0, idx, 2'h0};
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        for (i = 0; i < 100 && !b; i++) begin
            @(negedge aclk);
            a = req.awvalid && rsp.awready;
            w = req.wvalid && rsp.wready;
            b = rsp.bvalid;
            r = rsp.bresp;
            @(posedge aclk);
            if (a) req.awvalid <= 1'b0;
            if (w) req.wvalid <= 1'b0;
            if (b) req.bready <= 1'b0;
        end
        timeout(b);
    endtask
    task automatic axr(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] r);
        logic a, b;
        int i;
        b = 1'b0;
        @(posedge aclk);
        req.araddr <= {2'h0, idx, 2'h0};
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        for (i = 0; i < 100 && !b; i++) begin
            @(negedge aclk);
            a = req.arvalid && rsp.arready;
            b = rsp.rvalid;
            d = rsp.rdata;
            r = rsp.rresp;
            @(posedge aclk);
            if (a) req.arvalid <= 1'b0;
            if (b) req.rready <= 1'b0;
        end
        timeout(b);
    endtask
    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        logic [1:0] r;
        axw(idx, d, r);
        chk("write response", {30'h0, r}, {30'h0, sles_pkg::RESP_OKAY});
    endtask
    task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axr(idx, d, r);
        chk("read data", d, exp);
        chk("read response", {30'h0, r}, {30'h0, sles_pkg::RESP_OKAY});
    endtask
    task automatic inject(input logic l, input logic [7:0] dm, input logic [1:0] nm);
        int i;
        go <= 1'b1;
        link <= l;
        disp <= dm;
        nit <= nm;
        len <= 8'h01;
        @(posedge aclk);
        go <= 1'b0;
        for (i = 0; i < 100 && (i < 2 || busy); i++) @(posedge aclk);
        timeout(!busy);
    endtask
    task automatic do_reset_rows();
        logic [31:0] d;
        logic [1:0] r;
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[k]) begin
            axr(rows[k].idx, d, r);
            chk("reset response", {30'h0, r}, {30'h0, rows[k].resp});
            if (rows[k].resp === sles_pkg::RESP_OKAY) chk("reset value", d, rows[k].exp);
        end
        $display("Test reset values done");
    endtask
    initial begin
        ce = 1'b1;
        req = '0;
        {go, link, disp, nit, len, align} = '0;
        do_reset_rows();
        wr(sles_pkg::IDX_DISP_FLAGS, 32'hff);
        rd(sles_pkg::IDX_DISP_FLAGS, 32'h0);
        $display("Test read-only status done");
        inject(1'b0, 8'h81, 2'h0);
        inject(1'b0, 8'h81, 2'h2);
        inject(1'b1, 8'h02, 2'h0);
        wr(sles_pkg::IDX_ERR_THRESH, 32'h2);
        rd(sles_pkg::IDX_DISP_FLAGS, 32'h81);
        rd(sles_pkg::IDX_NIT_FLAGS, 32'h0);
        wr(sles_pkg::IDX_ERR_THRESH, 32'h1);
        rd(sles_pkg::IDX_NIT_FLAGS, 32'h80);
        wr(sles_pkg::IDX_LINK_PAGE, 32'h1);
        rd(sles_pkg::IDX_DISP_FLAGS, 32'h02);
        rd(sles_pkg::IDX_NIT_FLAGS, 32'h0);
        align <= 2'h1;
        rd(sles_pkg::IDX_LANE_ALIGN, 32'h0);
        wr(sles_pkg::IDX_LINK_PAGE, 32'h0);
        rd(sles_pkg::IDX_LANE_ALIGN, 32'h1);
        wr(sles_pkg::IDX_ERR_THRESH, 32'h0);
        rd(sles_pkg::IDX_DISP_FLAGS, 32'hff);
        wr(sles_pkg::IDX_ERR_THRESH, 32'h2);
        // Events while the clock enable is low must not count
        ce <= 1'b0;
        inject(1'b0, 8'h02, 2'h1);
        ce <= 1'b1;
        rd(sles_pkg::IDX_DISP_FLAGS, 32'h81);
        inject(1'b0, 8'h02, 2'h1);
        inject(1'b0, 8'h02, 2'h1);
        rd(sles_pkg::IDX_DISP_FLAGS, 32'h83);
        rd(sles_pkg::IDX_NIT_FLAGS, 32'h40);
        $display("Test lane flags and paging done");
        align <= 2'h0;
        do_reset_rows();
        end_sim();
    end
endmodule
